// ### sim/pil_ctrl_asserts.sv
// Concurrent checks on the controller's ports
`timescale 1ns/10ps
module pil_ctrl_asserts
  import pil_pkg::*;
#(
  parameter bit MGMT_EN  = 1'b1,
  parameter bit TBI_MODE = 1'b0,
  parameter bit DUAL_STD = 1'b1
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_mgmt_wr,
  input  wire logic [ADDR_W-1:0] i_mgmt_addr,
  input  wire logic [REG_W-1:0]  i_mgmt_wdata,
  input  wire logic              i_cfg_load,
  input  wire logic [REG_W-1:0]  i_cfg_reg0,
  input  wire logic [REG_W-1:0]  i_cfg_reg4,
  input  wire logic              i_rx_ready,
  input  wire logic [CODE_W-1:0] o_xcvr_tx_data,
  input  wire logic [1:0]        o_xcvr_loopback,
  input  wire logic              o_xcvr_powerdown,
  input  wire logic              o_ewrap,
  input  wire logic [CODE_W-1:0] o_rx_data,
  input  wire logic              o_rx_valid,
  input  wire logic              o_isolate,
  input  wire logic              o_loopback,
  input  wire logic              o_sgmii_mode,
  input  wire logic [REG_W-1:0]  o_an_adv,
  input  wire logic              o_core_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic wr_ctrl = MGMT_EN && i_mgmt_wr && i_mgmt_addr == ADDR_CTRL;
  wire logic wr_std  = MGMT_EN && DUAL_STD && i_mgmt_wr && i_mgmt_addr == ADDR_STD;
  sequence s_soft_rst;
    wr_ctrl && i_mgmt_wdata[15];
  endsequence
  sequence s_loop_held;
    (o_loopback && !TBI_MODE)[*3];
  endsequence
  a_xcvr_loop_off: assert property (o_xcvr_loopback == XCVR_LOOP_OFF)
    else $error("transceiver loopback control not zero");
  a_pdown_enter: assert property (wr_ctrl && i_mgmt_wdata[CTRL_PDOWN_BIT] && !o_core_reset
    |=> o_xcvr_powerdown) else $error("power-down write ignored");
  a_pdown_hold: assert property (o_xcvr_powerdown && !o_core_reset |=> o_xcvr_powerdown)
    else $error("power-down left without reset");
  a_soft_reset: assert property (s_soft_rst |=> o_core_reset ##1 (!o_core_reset
    && o_isolate && !o_loopback && !o_xcvr_powerdown)) else $error("soft reset did not restore");
  a_loop_write: assert property (wr_ctrl && !i_mgmt_wdata[15] && !o_core_reset
    |=> o_loopback == $past(i_mgmt_wdata[CTRL_LOOP_BIT])) else $error("loopback write lost");
  a_std_write: assert property (wr_std && !o_core_reset
    |=> o_sgmii_mode == $past(i_mgmt_wdata[STD_SGMII_BIT])) else $error("standard not switched");
  a_cfg_adv: assert property (MGMT_EN && i_cfg_load && !i_cfg_reg0[15] && !o_core_reset
    && !(i_mgmt_wr && i_mgmt_addr == ADDR_ADV) |=> o_an_adv == $past(i_cfg_reg4))
    else $error("vector load of advertisement lost");
  a_idle_loop: assert property (s_loop_held |-> o_xcvr_tx_data inside {IDLE_COMMA, IDLE_DATA})
    else $error("serial output not idle in loopback");
  a_ewrap_mode: assert property ((o_loopback == $past(o_loopback))[*2]
    |-> o_ewrap == (o_loopback && TBI_MODE)) else $error("wrap request wrong");
  a_rx_hold: assert property (o_rx_valid && !i_rx_ready && !o_isolate && !o_xcvr_powerdown
    && !o_core_reset && !i_mgmt_wr && !i_cfg_load |=> o_rx_valid && $stable(o_rx_data))
    else $error("stalled word lost");
  a_iso_quiet: assert property (o_isolate[*2] |-> !o_rx_valid)
    else $error("data passed while isolated");
endmodule

bind pil_ctrl pil_ctrl_asserts #(.MGMT_EN(MGMT_EN), .TBI_MODE(TBI_MODE), .DUAL_STD(DUAL_STD)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mgmt_wr(i_mgmt_wr), .i_mgmt_addr(i_mgmt_addr),
  .i_mgmt_wdata(i_mgmt_wdata), .i_cfg_load(i_cfg_load), .i_cfg_reg0(i_cfg_reg0),
  .i_cfg_reg4(i_cfg_reg4), .i_rx_ready(i_rx_ready), .o_xcvr_tx_data(o_xcvr_tx_data),
  .o_xcvr_loopback(o_xcvr_loopback), .o_xcvr_powerdown(o_xcvr_powerdown), .o_ewrap(o_ewrap),
  .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_isolate(o_isolate),
  .o_loopback(o_loopback), .o_sgmii_mode(o_sgmii_mode), .o_an_adv(o_an_adv),
  .o_core_reset(o_core_reset));

// ### sim/pil_mac_model.sv
// Client-side receiver model with commanded stalls
`timescale 1ns/10ps
module pil_mac_model
  import pil_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_stall,
  input  wire logic              i_valid,
  input  wire logic [CODE_W-1:0] i_data,
  output logic                   o_ready
);
  logic [CODE_W-1:0] got[$];
  initial o_ready = 1'b0;
  // Runs on the controller's own clock, no crossing
  always @(negedge i_clk) o_ready <= !i_stall;
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      got.push_back(i_data);
    end
  end
endmodule

// ### sim/tb_pil_ctrl.sv
// Self-checking bench for the power, isolate and loopback controller
`timescale 1ns/10ps
module tb_pil_ctrl
  import pil_pkg::*;
();
  typedef struct {logic [4:0] a; logic [15:0] d; logic [3:0] e;} pil_row_t;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, ld = 1'b0, txv = 1'b0, stall = 1'b0;
  logic [4:0]  addr = 5'h00, vec = 5'h08;
  logic [15:0] wd = 16'h0000, r0 = 16'h0000, r4 = 16'h0000, adv;
  logic [9:0]  txd = 10'h000, xrd = 10'h000, txo, rxd;
  logic        xrv = 1'b0;
  logic [1:0]  xl;
  logic        txr, pd, ew, rxv, rxr, iso, lp, sg, an, ovf, crst, pd2, ew2;
  int          fails = 0, checked = 0;
  pil_row_t    rows[7] = '{'{5'h00, 16'h1000, 4'h0}, '{5'h00, 16'h5000, 4'h4},
    '{5'h11, 16'h0001, 4'h5}, '{5'h1F, 16'hFFFF, 4'h5}, '{5'h11, 16'h0000, 4'h4},
    '{5'h00, 16'h1400, 4'h8}, '{5'h00, 16'h1000, 4'h0}};
  always #2 clk = ~clk;
  pil_ctrl uut (.i_clk(clk), .i_rst_n(rst_n), .i_mgmt_wr(wr), .i_mgmt_addr(addr),
    .i_mgmt_wdata(wd), .i_cfg_load(ld), .i_cfg_reg0(r0), .i_cfg_reg4(r4), .i_cfg_vec(vec),
    .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(txr), .i_xcvr_rx_data(xrd),
    .i_xcvr_rx_valid(xrv), .o_xcvr_tx_data(txo), .o_xcvr_loopback(xl),
    .o_xcvr_powerdown(pd), .o_ewrap(ew), .o_rx_data(rxd), .o_rx_valid(rxv),
    .i_rx_ready(rxr), .o_isolate(iso), .o_loopback(lp), .o_sgmii_mode(sg),
    .o_an_enable(an), .o_an_adv(adv), .o_rx_overflow(ovf), .o_core_reset(crst));
  pil_ctrl #(.MGMT_EN(1'b0), .TBI_MODE(1'b1)) uut_tbi (.i_clk(clk), .i_rst_n(rst_n),
    .i_mgmt_wr(wr), .i_mgmt_addr(addr), .i_mgmt_wdata(wd), .i_cfg_load(ld), .i_cfg_reg0(r0),
    .i_cfg_reg4(r4), .i_cfg_vec(vec), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(),
    .i_xcvr_rx_data(10'h000), .i_xcvr_rx_valid(1'b0), .o_xcvr_tx_data(),
    .o_xcvr_loopback(), .o_xcvr_powerdown(pd2), .o_ewrap(ew2), .o_rx_data(), .o_rx_valid(),
    .i_rx_ready(rxr), .o_isolate(), .o_loopback(), .o_sgmii_mode(), .o_an_enable(),
    .o_an_adv(), .o_rx_overflow(), .o_core_reset());
  pil_mac_model mac (.i_clk(clk), .i_stall(stall), .i_valid(rxv), .i_data(rxd), .o_ready(rxr));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic conclude();
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic mwr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic send(input logic [9:0] d);
    int k;
    @(negedge clk);
    txv = 1'b1;
    txd = d;
    for (k = 0; k < 20; k++) begin
      if (txr) break;
      @(negedge clk);
    end
    if (k == 20) begin
      fails++;
      conclude();
    end
    @(negedge clk);
    txv = 1'b0;
  endtask
  task automatic drain(input int n);
    for (int k = 0; k < 20 && mac.got.size() < n; k++) @(negedge clk);
    if (mac.got.size() < n) begin
      fails++;
      conclude();
    end
  endtask

  initial begin
    #20000;
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk("reset state", 16'h0011, {iso, lp, pd, ew, an});
    chk("reset adv", 16'h0020, adv);
    chk("xcvr loopback", 16'h0000, xl);
    foreach (rows[i]) begin
      mwr(rows[i].a, rows[i].d);
      chk("control state", {12'h000, rows[i].e}, {12'h000, iso, lp, pd, sg});
    end
    stall = 1'b1;
    mwr(ADDR_CTRL, 16'h5000);
    send(10'h155);
    send(10'h2AA);
    chk("tx ready when full", 16'h0000, txr);
    chk("idle stream", 16'h0001, txo == IDLE_COMMA || txo == IDLE_DATA);
    chk("xcvr loopback", 16'h0000, xl);
    stall = 1'b0;
    drain(2);
    chk("looped word 0", 16'h0155, mac.got[0]);
    chk("looped word 1", 16'h02AA, mac.got[1]);
    @(negedge clk);
    ld = 1'b1;
    r0 = 16'h1000;
    r4 = 16'h01A0;
    @(negedge clk);
    ld = 1'b0;
    chk("vector load", 16'h01A0, {adv[15:1], lp});
    stall = 1'b1;
    txd = 10'h17C;
    xrv = 1'b1;
    xrd = 10'h0F0;
    @(negedge clk);
    chk("transmit path", 16'h017C, txo);
    xrd = 10'h30F;
    @(negedge clk);
    xrd = 10'h3C3;
    @(negedge clk);
    xrv = 1'b0;
    chk("rx overflow", 16'h0001, ovf);
    stall = 1'b0;
    drain(4);
    chk("received word 0", 16'h00F0, mac.got[2]);
    chk("received word 1", 16'h030F, mac.got[3]);
    mwr(ADDR_CTRL, 16'h4800);
    chk("power-down entry", 16'h0001, pd);
    mwr(ADDR_CTRL, 16'h4000);
    chk("power-down kept", 16'h0001, pd);
    mwr(ADDR_CTRL, 16'h8000);
    chk("core reset", 16'h0001, crst);
    @(negedge clk);
    chk("after soft reset", 16'h0002, {ovf, lp, pd, iso, crst});
    vec = 5'h06;
    repeat (3) @(negedge clk);
    chk("vector power-down", 16'h0003, {pd2, ew2});
    vec = 5'h00;
    repeat (3) @(negedge clk);
    chk("vector power-down kept", 16'h0002, {pd2, ew2});
    mwr(ADDR_CTRL, 16'h0800);
    rst_n = 1'b0;
    @(negedge clk);
    chk("port reset", 16'h0000, {pd, pd2});
    rst_n = 1'b1;
    conclude();
  end
endmodule

// ### src/pil_ctrl.sv
// PCS power-down, isolate, loopback and standard select controller
`timescale 1ns/10ps
module pil_ctrl
  import pil_pkg::*;
#(
  parameter bit MGMT_EN   = 1'b1,
  parameter bit TBI_MODE  = 1'b0,
  parameter bit DUAL_STD  = 1'b1,
  parameter bit DEF_SGMII = 1'b0
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_mgmt_wr,
  input  wire logic [ADDR_W-1:0] i_mgmt_addr,
  input  wire logic [REG_W-1:0]  i_mgmt_wdata,
  input  wire logic              i_cfg_load,
  input  wire logic [REG_W-1:0]  i_cfg_reg0,
  input  wire logic [REG_W-1:0]  i_cfg_reg4,
  input  wire logic [VEC_W-1:0]  i_cfg_vec,
  input  wire logic [CODE_W-1:0] i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  input  wire logic [CODE_W-1:0] i_xcvr_rx_data,
  input  wire logic              i_xcvr_rx_valid,
  output logic [CODE_W-1:0]      o_xcvr_tx_data,
  output logic [1:0]             o_xcvr_loopback,
  output logic                   o_xcvr_powerdown,
  output logic                   o_ewrap,
  output logic [CODE_W-1:0]      o_rx_data,
  output logic                   o_rx_valid,
  input  wire logic              i_rx_ready,
  output logic                   o_isolate,
  output logic                   o_loopback,
  output logic                   o_sgmii_mode,
  output logic                   o_an_enable,
  output logic [REG_W-1:0]       o_an_adv,
  output logic                   o_rx_overflow,
  output logic                   o_core_reset
);
  // Control register state
  logic             loop_en;
  logic             pdown;
  logic             iso;
  logic             aneg;
  logic [REG_W-1:0] adv;
  logic             sgmii;
  logic             soft_rst;
  logic             ovf;
  logic             next_loop_en;
  logic             next_pdown;
  logic             next_iso;
  logic             next_aneg;
  logic [REG_W-1:0] next_adv;
  logic             next_sgmii;
  logic             next_soft_rst;
  logic             next_ovf;
  // Serial output state
  logic [CODE_W-1:0] ser;
  logic              idle_ph;
  logic              ewrap;
  logic [CODE_W-1:0] next_ser;
  logic              next_idle_ph;
  logic              next_ewrap;
  // Write decode and receive path control
  logic              wr_ctrl;
  logic              wr_adv;
  logic              wr_std;
  logic              cfg_ld;
  logic              loop_int;
  logic              rx_in_valid;
  logic              path_off;

  pil_stream_if #(.W(CODE_W)) rx_in ();
  pil_stream_if #(.W(CODE_W)) rx_out ();

  function automatic logic hit(input logic wr, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] target);
    hit = wr && (a == target);
  endfunction

  assign wr_ctrl  = MGMT_EN && hit(i_mgmt_wr, i_mgmt_addr, ADDR_CTRL);
  assign wr_adv   = MGMT_EN && hit(i_mgmt_wr, i_mgmt_addr, ADDR_ADV);
  assign wr_std   = MGMT_EN && DUAL_STD && hit(i_mgmt_wr, i_mgmt_addr, ADDR_STD);
  assign cfg_ld   = MGMT_EN && i_cfg_load;
  assign loop_int = loop_en && !TBI_MODE;
  assign path_off = iso || pdown;

  always_comb begin
    next_loop_en  = loop_en;
    next_pdown    = pdown;
    next_iso      = iso;
    next_aneg     = aneg;
    next_adv      = adv;
    next_sgmii    = sgmii;
    next_soft_rst = 1'b0;
    if (MGMT_EN) begin
      // Vector load first, so a same-cycle management write wins
      if (cfg_ld) begin
        next_loop_en  = i_cfg_reg0[CTRL_LOOP_BIT];
        next_aneg     = i_cfg_reg0[CTRL_ANEG_BIT];
        next_pdown    = pdown | i_cfg_reg0[CTRL_PDOWN_BIT];
        next_iso      = i_cfg_reg0[CTRL_ISO_BIT];
        next_adv      = i_cfg_reg4;
        next_soft_rst = i_cfg_reg0[CTRL_RESET_BIT];
      end
      if (wr_ctrl) begin
        next_loop_en  = i_mgmt_wdata[CTRL_LOOP_BIT];
        next_aneg     = i_mgmt_wdata[CTRL_ANEG_BIT];
        // Power-down cannot be cleared by writing its bit; only the soft reset or the reset port clears it
        next_pdown    = pdown | i_mgmt_wdata[CTRL_PDOWN_BIT];
        next_iso      = i_mgmt_wdata[CTRL_ISO_BIT];
        next_soft_rst = i_mgmt_wdata[CTRL_RESET_BIT];
      end
      if (wr_adv) begin
        next_adv = i_mgmt_wdata;
      end
      if (wr_std) begin
        next_sgmii = i_mgmt_wdata[STD_SGMII_BIT];
      end
      if (soft_rst) begin
        next_loop_en = RST_LOOP;
        next_pdown   = RST_PDOWN;
        next_iso     = RST_ISO;
        next_aneg    = RST_ANEG;
        next_adv     = RST_ADV;
        next_sgmii   = DEF_SGMII;
      end
    end else begin
      next_loop_en = i_cfg_vec[VEC_LOOP_BIT];
      next_iso     = i_cfg_vec[VEC_ISO_BIT];
      next_aneg    = i_cfg_vec[VEC_ANEG_BIT];
      // Sticky until the reset port
      next_pdown   = pdown | i_cfg_vec[VEC_PDOWN_BIT];
    end
    // Overflow set wins over the clear by core reset
    next_ovf = (rx_in_valid && !rx_in.ready) || (ovf && !soft_rst);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loop_en  <= RST_LOOP;
      pdown    <= RST_PDOWN;
      iso      <= RST_ISO;
      aneg     <= RST_ANEG;
      adv      <= RST_ADV;
      sgmii    <= DEF_SGMII;
      soft_rst <= 1'b0;
      ovf      <= 1'b0;
    end else begin
      loop_en  <= next_loop_en;
      pdown    <= next_pdown;
      iso      <= next_iso;
      aneg     <= next_aneg;
      adv      <= next_adv;
      sgmii    <= next_sgmii;
      soft_rst <= next_soft_rst;
      ovf      <= next_ovf;
    end
  end

  // Receive source: wrapped transmit data or the transceiver
  assign rx_in_valid = !path_off && (loop_int ? i_tx_valid : i_xcvr_rx_valid);
  assign rx_in.valid = rx_in_valid;
  assign rx_in.data  = loop_int ? i_tx_data : i_xcvr_rx_data;

  pil_skid_buf #(.W(CODE_W)) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_flush (path_off || soft_rst),
    .s_in    (rx_in),
    .s_out   (rx_out)
  );
  assign rx_out.ready = i_rx_ready;

  always_comb begin
    next_idle_ph = ~idle_ph;
    next_ewrap   = loop_en && TBI_MODE;
    if (path_off || loop_int) begin
      next_ser = idle_ph ? IDLE_DATA : IDLE_COMMA;
    end else begin
      next_ser = i_tx_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser     <= IDLE_COMMA;
      idle_ph <= 1'b0;
      ewrap   <= 1'b0;
    end else begin
      ser     <= next_ser;
      idle_ph <= next_idle_ph;
      ewrap   <= next_ewrap;
    end
  end

  assign o_tx_ready       = rx_in.ready;
  assign o_rx_data        = rx_out.data;
  assign o_rx_valid       = rx_out.valid;
  assign o_xcvr_tx_data   = ser;
  assign o_xcvr_loopback  = XCVR_LOOP_OFF;
  assign o_xcvr_powerdown = pdown;
  assign o_ewrap          = ewrap;
  assign o_isolate        = iso;
  assign o_loopback       = loop_en;
  assign o_sgmii_mode     = sgmii;
  assign o_an_enable      = aneg;
  assign o_an_adv         = adv;
  assign o_rx_overflow    = ovf;
  assign o_core_reset     = soft_rst;
endmodule

// ### src/pil_pkg.sv
// Shared constants for the PCS power, isolate and loopback controller
package pil_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          REG_W           = 16;
  localparam int          CODE_W          = 10;
  localparam int          VEC_W           = 5;
  // Management register addresses
  localparam logic [4:0]  ADDR_CTRL       = 5'h00;
  localparam logic [4:0]  ADDR_ADV        = 5'h04;
  localparam logic [4:0]  ADDR_STD        = 5'h11;
  // Control register 0 field positions
  localparam int          CTRL_RESET_BIT  = 15;
  localparam int          CTRL_LOOP_BIT   = 14;
  localparam int          CTRL_ANEG_BIT   = 12;
  localparam int          CTRL_PDOWN_BIT  = 11;
  localparam int          CTRL_ISO_BIT    = 10;
  // Standard select register field
  localparam int          STD_SGMII_BIT   = 0;
  // Static configuration vector field positions
  localparam int          VEC_LOOP_BIT    = 1;
  localparam int          VEC_PDOWN_BIT   = 2;
  localparam int          VEC_ISO_BIT     = 3;
  localparam int          VEC_ANEG_BIT    = 4;
  // Reset values
  localparam logic        RST_LOOP        = 1'b0;
  localparam logic        RST_PDOWN       = 1'b0;
  localparam logic        RST_ISO         = 1'b1;
  localparam logic        RST_ANEG        = 1'b1;
  localparam logic [15:0] RST_ADV         = 16'h0020;
  localparam logic [1:0]  XCVR_LOOP_OFF   = 2'b00;
  // Idle ordered set: comma then data code group
  localparam logic [9:0]  IDLE_COMMA      = 10'h0FA;
  localparam logic [9:0]  IDLE_DATA       = 10'h245;
endpackage

// ### src/pil_skid_buf.sv
// Two-entry buffer with registered ready and registered outputs
`timescale 1ns/10ps
module pil_skid_buf
  import pil_pkg::*;
#(
  parameter int W = CODE_W
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_flush,
  pil_stream_if.snk  s_in,
  pil_stream_if.src  s_out
);
  logic         head_valid;
  logic         skid_valid;
  logic [W-1:0] head;
  logic [W-1:0] skid;
  logic         next_head_valid;
  logic         next_skid_valid;
  logic [W-1:0] next_head;
  logic [W-1:0] next_skid;
  logic         push;
  logic         pop;

  assign push         = s_in.valid & ~skid_valid;
  assign pop          = head_valid & s_out.ready;
  assign s_in.ready   = ~skid_valid;
  assign s_out.valid  = head_valid;
  assign s_out.data   = head;

  always_comb begin
    next_head_valid = head_valid;
    next_skid_valid = skid_valid;
    next_head       = head;
    next_skid       = skid;
    if (pop && skid_valid) begin
      next_head       = skid;
      next_skid_valid = 1'b0;
    end else if (pop) begin
      next_head_valid = push;
      next_head       = s_in.data;
    end else if (push && !head_valid) begin
      next_head_valid = 1'b1;
      next_head       = s_in.data;
    end else if (push) begin
      next_skid_valid = 1'b1;
      next_skid       = s_in.data;
    end
    if (i_flush) begin
      next_head_valid = 1'b0;
      next_skid_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      head_valid <= 1'b0;
      skid_valid <= 1'b0;
      head       <= '0;
      skid       <= '0;
    end else begin
      head_valid <= next_head_valid;
      skid_valid <= next_skid_valid;
      head       <= next_head;
      skid       <= next_skid;
    end
  end
endmodule

// ### src/pil_stream_if.sv
// Valid/ready stream carrier between the controller and its buffer
`timescale 1ns/10ps
interface pil_stream_if #(
  parameter int W = 10
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
